//--- psc_pkg.sv
package psc_pkg;
  // ---------------------------------------------------------------------------
  // widths and encodings
  // ---------------------------------------------------------------------------
  localparam int PSC_WORD_W = 16;
  localparam int PSC_PROD_W = 32;
  localparam int PSC_PC_W = 16;
  localparam logic [15:0] PSC_LOAD_SHIFT_MASK = 16'hfffc;
  localparam logic [15:0] PSC_LOAD_SHIFT_CODE = 16'hce08;
  localparam int PSC_FIELD_LSB = 0;
  localparam logic [15:0] PSC_PC_STEP = 16'h0001;
  localparam int PSC_SHIFT_L1 = 1;
  localparam int PSC_SHIFT_L4 = 4;
  localparam int PSC_SHIFT_R6 = 6;
  localparam logic [1:0] PSC_FIELD_RESET = 2'h0;
  // product shift field position inside status word one
  localparam int PSC_ST1_PM_LSB = 0;

  typedef enum logic [1:0] {
    PSC_PM_NONE,
    PSC_PM_LEFT1,
    PSC_PM_LEFT4,
    PSC_PM_RIGHT6
  } psc_mode_t;
endpackage : psc_pkg

//--- psc_shifter.sv
module psc_shifter (
  // product in
  input wire logic [psc_pkg::PSC_PROD_W-1:0] prod_i,
  input wire psc_pkg::psc_mode_t mode_i,
  // shifted out
  output logic [psc_pkg::PSC_PROD_W-1:0] shifted_o
);
  import psc_pkg::*;

  always_comb begin
    unique case (mode_i)
      PSC_PM_NONE: shifted_o = prod_i;
      PSC_PM_LEFT1: shifted_o = prod_i << PSC_SHIFT_L1;
      PSC_PM_LEFT4: shifted_o = prod_i << PSC_SHIFT_L4;
      PSC_PM_RIGHT6: shifted_o = $signed(prod_i) >>> PSC_SHIFT_R6;
    endcase
  end
endmodule : psc_shifter

//--- psc_top.sv
// Summary of operation
// - load instruction copies opcode low bits
// - load: one word, one cycle, pc+1
// - mode zero passes product unshifted
// - mode one shifts left one, zero fill
// - mode two shifts left four, zero fill
// - mode three arithmetic right shift six
// - mode persists until field reloaded
// - status restore also loads field
// - right six gives 64-sum headroom
module psc_top (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  // instruction stream
  input wire logic INSTR_VALID_I,
  input wire logic [psc_pkg::PSC_WORD_W-1:0] INSTR_I,
  input wire logic [psc_pkg::PSC_PC_W-1:0] PC_I,
  // status word one restore
  input wire logic RESTORE_ST1_I,
  input wire logic [psc_pkg::PSC_WORD_W-1:0] ST1_DATA_I,
  // product register path
  input wire logic PROD_LOAD_I,
  input wire logic [psc_pkg::PSC_PROD_W-1:0] PROD_I,
  // outputs
  output logic [psc_pkg::PSC_PROD_W-1:0] PROD_Q_O,
  output logic [psc_pkg::PSC_PROD_W-1:0] ALU_OPERAND_O,
  output logic [1:0] PROD_SHIFT_FIELD_O,
  output logic [psc_pkg::PSC_PC_W-1:0] PC_NEXT_O,
  output logic LOAD_DONE_O
);
  import psc_pkg::*;

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  psc_mode_t field_q, field_d;
  logic [PSC_PROD_W-1:0] prod_q, prod_d;
  logic [PSC_PROD_W-1:0] alu_q, alu_d;
  logic [PSC_PC_W-1:0] pc_q, pc_d;
  logic [PSC_PC_W:0] pc_sum;
  logic done_q, done_d;
  logic [PSC_PROD_W-1:0] shifted;
  logic is_load;

  // the mask leaves the mode bits out, so all four settings decode
  assign is_load = INSTR_VALID_I && ((INSTR_I & PSC_LOAD_SHIFT_MASK) == PSC_LOAD_SHIFT_CODE);

  // ---------------------------------------------------------------------------
  // output shifter
  // ---------------------------------------------------------------------------
  // works on a copy of the register, so the stored product is never touched
  psc_shifter u_shift (
    .prod_i(prod_q),
    .mode_i(field_q),
    .shifted_o(shifted)
  );

  // ---------------------------------------------------------------------------
  // product shift field
  // ---------------------------------------------------------------------------
  // a load in the same cycle as a status restore takes priority
  always_comb begin
    field_d = field_q;
    if (is_load) begin
      field_d = psc_mode_t'(INSTR_I[PSC_FIELD_LSB +: $bits(psc_mode_t)]);
    end else if (RESTORE_ST1_I) begin
      field_d = psc_mode_t'(ST1_DATA_I[PSC_ST1_PM_LSB +: $bits(psc_mode_t)]);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      field_q <= psc_mode_t'(PSC_FIELD_RESET);
    end else begin
      field_q <= field_d;
    end
  end

  property p_field_idle;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      !INSTR_VALID_I && !RESTORE_ST1_I |=> $stable(PROD_SHIFT_FIELD_O);
  endproperty
  a_field_idle: assert property (p_field_idle) else $error("field moved while idle");

  // ---------------------------------------------------------------------------
  // product register and alu operand
  // ---------------------------------------------------------------------------
  always_comb begin
    prod_d = PROD_LOAD_I ? PROD_I : prod_q;
    alu_d = shifted;
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      prod_q <= '0;
      alu_q <= '0;
    end else begin
      prod_q <= prod_d;
      alu_q <= alu_d;
    end
  end

  property p_prod_load;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      PROD_LOAD_I |=> PROD_Q_O == $past(PROD_I);
  endproperty
  a_prod_load: assert property (p_prod_load) else $error("product not loaded");

  // with nothing reloaded for two cycles the same transfer repeats
  property p_steady_operand;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (!PROD_LOAD_I && !is_load && !RESTORE_ST1_I) [*2] |=> $stable(ALU_OPERAND_O);
  endproperty
  a_steady_operand: assert property (p_steady_operand) else $error("operand drifted");

  // ---------------------------------------------------------------------------
  // program counter step and completion pulse
  // ---------------------------------------------------------------------------
  always_comb begin
    pc_sum = {1'b0, PC_I} + {1'b0, PSC_PC_STEP};
    pc_d = is_load ? pc_sum[PSC_PC_W-1:0] : pc_q;
    done_d = is_load;
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pc_q <= '0;
      done_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      done_q <= done_d;
    end
  end

  property p_done_pulse;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      !is_load |=> !LOAD_DONE_O;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("completion without load");

  property p_pc_hold;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      !is_load |=> $stable(PC_NEXT_O);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved without load");

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  // every output is taken straight from a register
  assign PROD_Q_O = prod_q;
  assign ALU_OPERAND_O = alu_q;
  assign PROD_SHIFT_FIELD_O = field_q;
  assign PC_NEXT_O = pc_q;
  assign LOAD_DONE_O = done_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  property p_load_field;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      is_load |=> field_q == $past(INSTR_I[1:0]);
  endproperty
  a_load_field: assert property (p_load_field) else $error("field not loaded");

  property p_load_pc;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      is_load |=> LOAD_DONE_O && PC_NEXT_O == $past(PC_I) + PSC_PC_STEP;
  endproperty
  a_load_pc: assert property (p_load_pc) else $error("pc not advanced by one");

  property p_none;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      field_q == PSC_PM_NONE |=> ALU_OPERAND_O == $past(prod_q);
  endproperty
  a_none: assert property (p_none) else $error("mode zero shifted");

  property p_left1;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      field_q == PSC_PM_LEFT1 |=> ALU_OPERAND_O == {$past(prod_q[30:0]), 1'b0};
  endproperty
  a_left1: assert property (p_left1) else $error("left one wrong");

  property p_left4;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      field_q == PSC_PM_LEFT4 |=> ALU_OPERAND_O == {$past(prod_q[27:0]), 4'h0};
  endproperty
  a_left4: assert property (p_left4) else $error("left four wrong");

  property p_right6;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      field_q == PSC_PM_RIGHT6 |=> ALU_OPERAND_O == {{6{$past(prod_q[31])}}, $past(prod_q[31:6])};
  endproperty
  a_right6: assert property (p_right6) else $error("right six wrong");

  property p_hold;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      !is_load && !RESTORE_ST1_I |=> $stable(field_q);
  endproperty
  a_hold: assert property (p_hold) else $error("field changed unasked");

  property p_restore;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      RESTORE_ST1_I && !is_load |=> field_q == $past(ST1_DATA_I[1:0]);
  endproperty
  a_restore: assert property (p_restore) else $error("restore missed");

  // seven copies of the product sign leave room for 64 summed transfers
  property p_headroom;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      field_q == PSC_PM_RIGHT6 |=> ALU_OPERAND_O[31:25] == {7{$past(prod_q[31])}};
  endproperty
  a_headroom: assert property (p_headroom) else $error("no headroom");

  property p_prod_kept;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      !PROD_LOAD_I |=> $stable(prod_q);
  endproperty
  a_prod_kept: assert property (p_prod_kept) else $error("product altered");

  c_load: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) is_load);
  c_restore: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) RESTORE_ST1_I);
  c_right6: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) field_q == PSC_PM_RIGHT6);
  c_left4: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) field_q == PSC_PM_LEFT4);
  c_clash: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) is_load && RESTORE_ST1_I);
endmodule : psc_top

//--- psc_top_tb.sv
module product_shift_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import psc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ivld = 1'b0, rest = 1'b0, pld = 1'b0, done;
  logic [15:0] instr = 16'h0, pc = 16'h0, st1 = 16'h0, pcn;
  logic [31:0] prod = 32'h0, prod_q, alu;
  logic [1:0] fld;
  int error_cnt = 0, check_count = 0;
  always #25 clk = ~clk;
  psc_top i_dut (.SYS_CLK_I(clk), .NRST_I(rst_n), .INSTR_VALID_I(ivld), .INSTR_I(instr),
    .PC_I(pc), .RESTORE_ST1_I(rest), .ST1_DATA_I(st1), .PROD_LOAD_I(pld), .PROD_I(prod),
    .PROD_Q_O(prod_q), .ALU_OPERAND_O(alu), .PROD_SHIFT_FIELD_O(fld), .PC_NEXT_O(pcn),
    .LOAD_DONE_O(done));
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] shf(input logic [31:0] p, input logic [1:0] m);
    return (m == 2'h1) ? {p[30:0], 1'b0} : (m == 2'h2) ? {p[27:0], 4'h0} :
      (m == 2'h3) ? {{6{p[31]}}, p[31:6]} : p;
  endfunction : shf
  task automatic put_prod(input logic [31:0] v);
    prod = v;
    pld = 1'b1;
    @(negedge clk);
    pld = 1'b0;
  endtask : put_prod
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic test_modes();
    logic [31:0] v;
    v = 32'h8765_4321;
    put_prod(v);
    for (int i = 3; i >= 0; i--) begin
      ivld = 1'b1;
      instr = PSC_LOAD_SHIFT_CODE | 16'(i);
      pc = 16'hfff0 + 16'(i);
      @(negedge clk);
      ivld = 1'b0;
      chk(32'(fld), 32'(i));
      chk(32'(done), 32'h1);
      chk(32'(pcn), 32'(16'hfff1 + 16'(i)));
      @(negedge clk);
      chk(32'(done), 32'h0);
      chk(alu, shf(v, 2'(i)));
      chk(prod_q, v);
      v = ~v + 32'h0000_1357;
      put_prod(v);
      @(negedge clk);
      chk(alu, shf(v, 2'(i)));
    end
    $display("test modes done");
  endtask : test_modes
  task automatic test_restore();
    rest = 1'b1;
    st1 = 16'hfff2;
    @(negedge clk);
    rest = 1'b0;
    chk(32'(fld), 32'h2);
    ivld = 1'b1;
    instr = 16'hce09;
    rest = 1'b1;
    st1 = 16'h0003;
    @(negedge clk);
    rest = 1'b0;
    chk(32'(fld), 32'h1);
    instr = 16'hce0f;
    @(negedge clk);
    ivld = 1'b0;
    chk(32'(fld), 32'h1);
    chk(32'(done), 32'h0);
    $display("test restore done");
  endtask : test_restore
  initial begin
    repeat (16) @(negedge clk);
    chk(32'(fld), 32'h0);
    chk(alu, 32'h0);
    rst_n = 1'b1;
    @(negedge clk);
    test_modes();
    test_restore();
    final_report();
  end
endmodule : product_shift_control_tb
